// File: rtl/pbc_regs.vh
// register offsets, field positions, reset values and timing counts for the control register
`ifndef PBC_REGS_VH
`define PBC_REGS_VH

// ****************************************
// register map
// ****************************************
`define PBC_CTRL_ADDR 5'h00
`define PBC_CTRL_RESET 16'h0000

// ****************************************
// field positions
// ****************************************
`define PBC_BIT_SW_RESET 15
`define PBC_BIT_LOOPBACK 14
`define PBC_BIT_SPEED 13
`define PBC_BIT_AN_EN 12
`define PBC_BIT_PWRDN 11
`define PBC_BIT_ISOLATE 10
`define PBC_BIT_AN_RESTART 9
`define PBC_BIT_DUPLEX 8
`define PBC_BIT_COL_TEST 7

// ****************************************
// timing
// ****************************************
`define PBC_CLK_PERIOD_NS 50
`define PBC_SW_RESET_NS 25000
// 25 us at 50 ns per clock; recount if the clock changes
`define PBC_SW_RESET_CYCLES 10'h1f4
`define PBC_STRAP_SETTLE_CYCLES 10'h003

`endif

// File: rtl/pbc_mii_path.v
// mii pin steering for loopback, isolate, powerdown and collision test
`timescale 1ns/1ps
`default_nettype none

module pbc_mii_path (
  input wire ref_clk,
  input wire reset_n,
  input wire loopback,
  input wire isolate,
  input wire powerdown,
  input wire col_test,
  input wire [3:0] mac_txd,
  input wire mac_tx_en,
  input wire mac_tx_er,
  input wire [3:0] pcs_rxd,
  input wire pcs_rx_dv,
  input wire pcs_rx_er,
  input wire pcs_col,
  input wire pcs_crs,
  input wire pcs_tx_clk,
  input wire pcs_rx_clk,
  output reg [3:0] pcs_txd,
  output reg pcs_tx_en,
  output reg pcs_tx_er,
  output wire twisted_pair_tx_oe,
  output wire led_oe,
  output reg [3:0] mii_rxd,
  output reg mii_rx_dv,
  output reg mii_rx_er,
  output reg mii_col,
  output reg mii_crs,
  output reg mii_tx_clk,
  output reg mii_rx_clk,
  output wire mii_out_oe
);

  // ****************************************
  // pin isolation
  // ****************************************
  wire mii_cut;
  assign mii_cut = isolate | powerdown;
  assign mii_out_oe = ~mii_cut;
  // loopback keeps the line quiet so looped frames never reach the partner
  assign twisted_pair_tx_oe = ~(loopback | powerdown);
  assign led_oe = ~powerdown;

  // ****************************************
  // datapath registers
  // ****************************************
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pcs_txd <= 4'h0;
      pcs_tx_en <= 1'b0;
      pcs_tx_er <= 1'b0;
      mii_rxd <= 4'h0;
      mii_rx_dv <= 1'b0;
      mii_rx_er <= 1'b0;
      mii_col <= 1'b0;
      mii_crs <= 1'b0;
      mii_tx_clk <= 1'b0;
      mii_rx_clk <= 1'b0;
    end else begin
      // an isolated port ignores everything the mac drives
      pcs_txd <= (mii_cut | loopback) ? 4'h0 : mac_txd;
      pcs_tx_en <= ~mii_cut & ~loopback & mac_tx_en;
      pcs_tx_er <= ~mii_cut & ~loopback & mac_tx_er;
      mii_tx_clk <= pcs_tx_clk;
      mii_rx_clk <= pcs_rx_clk;
      mii_crs <= loopback ? mac_tx_en : pcs_crs;
      if (loopback) begin
        mii_rxd <= mac_txd;
        mii_rx_dv <= mac_tx_en;
        mii_rx_er <= mac_tx_er;
      end else begin
        mii_rxd <= pcs_rxd;
        mii_rx_dv <= pcs_rx_dv;
        mii_rx_er <= pcs_rx_er;
      end
      mii_col <= (loopback ? 1'b0 : pcs_col) | (col_test & mac_tx_en);
    end
  end

endmodule

`default_nettype wire

// File: rtl/pbc_ctrl.v
// basic control register of the phy with strap defaults and datapath side effects
//
// What this block does
// - writing bit 15 starts whole-phy soft reset
// - soft reset re-samples every configuration strap
// - soft reset lasts 25 us, bit reads one
// - loopback disconnects twisted pair transmit outputs
// - loopback returns mac transmit nibbles to receive
// - loopback phy speed from enable and speed bits
// - manual speed bit 13 unless autonegotiation on
// - speed defaults one unless three straps low
// - bit 12 picks autonegotiated or manual mode
// - autonegotiation enable defaults from its strap
// - powerdown tri-states line, leds, isolates mii
// - hardware reset clears the powerdown bit
// - isolate ignores mac inputs, floats mii outputs
// - management access keeps working while isolated
// - isolate defaults one when strapped address zero
// - restart bit starts autonegotiation when enabled
// - restart bit clears after autonegotiation completes
// - manual duplex bit 8 selects full or half
// - duplex defaults from straps when autonegotiation off
// - collision test raises col with tx enable
// - hardware reset latches five address straps
`timescale 1ns/1ps
`default_nettype none
`include "pbc_regs.vh"

module pbc_ctrl (
  input wire ref_clk,
  input wire reset_n,
  input wire autoneg_strap,
  input wire fast_full_duplex_strap,
  input wire fast_half_duplex_strap,
  input wire slow_full_duplex_strap,
  input wire [4:0] phy_addr_strap,
  input wire [4:0] mgmt_reg_addr,
  input wire mgmt_wr_en,
  input wire [15:0] mgmt_wr_data,
  input wire mgmt_rd_en,
  output reg [15:0] mgmt_rd_data_ff,
  output reg mgmt_rd_valid_ff,
  output reg [4:0] phy_addr_ff,
  input wire an_done,
  input wire an_speed_100,
  input wire an_full_duplex,
  output reg an_restart_ff,
  output reg an_enable_ff,
  output reg link_speed_100_ff,
  output reg link_full_duplex_ff,
  output reg soft_reset_ff,
  input wire [3:0] mac_txd,
  input wire mac_tx_en,
  input wire mac_tx_er,
  input wire [3:0] pcs_rxd,
  input wire pcs_rx_dv,
  input wire pcs_rx_er,
  input wire pcs_col,
  input wire pcs_crs,
  input wire pcs_tx_clk,
  input wire pcs_rx_clk,
  output wire [3:0] pcs_txd,
  output wire pcs_tx_en,
  output wire pcs_tx_er,
  output wire twisted_pair_tx_oe,
  output wire led_oe,
  output wire [3:0] mii_rxd,
  output wire mii_rx_dv,
  output wire mii_rx_er,
  output wire mii_col,
  output wire mii_crs,
  output wire mii_tx_clk,
  output wire mii_rx_clk,
  output wire mii_out_oe
);

  // ****************************************
  // states and constants
  // ****************************************
  localparam [1:0] ST_STRAP = 2'b00;
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_SWRST = 2'b10;
  localparam [9:0] SWRST_LAST = `PBC_SW_RESET_CYCLES - 10'h001;
  localparam [9:0] STRAP_LAST = `PBC_STRAP_SETTLE_CYCLES - 10'h001;

  // ****************************************
  // strap synchronisers
  // ****************************************
  wire [8:0] strap_pins;
  wire [8:0] strap_sync;
  reg [8:0] strap_meta_ff;
  reg [8:0] strap_sync_ff;
  assign strap_pins = {phy_addr_strap, slow_full_duplex_strap, fast_half_duplex_strap,
                       fast_full_duplex_strap, autoneg_strap};

  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1) begin : g_strap_sync
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          strap_meta_ff[gi] <= 1'b0;
          strap_sync_ff[gi] <= 1'b0;
        end else begin
          strap_meta_ff[gi] <= strap_pins[gi];
          strap_sync_ff[gi] <= strap_meta_ff[gi];
        end
      end
    end
  endgenerate
  assign strap_sync = strap_sync_ff;

  // ****************************************
  // decode helpers
  // ****************************************
  function ctrl_hit;
    input [4:0] addr;
    begin
      ctrl_hit = (addr == `PBC_CTRL_ADDR);
    end
  endfunction

  // ****************************************
  // register state
  // ****************************************
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [9:0] cnt_ff;
  reg [9:0] nxt_cnt;
  reg loopback_ff;
  reg nxt_loopback;
  reg speed_ff;
  reg nxt_speed;
  reg an_en_ff;
  reg nxt_an_en;
  reg pwrdn_ff;
  reg nxt_pwrdn;
  reg isolate_ff;
  reg nxt_isolate;
  reg restart_ff;
  reg nxt_restart;
  reg duplex_ff;
  reg nxt_duplex;
  reg col_test_ff;
  reg nxt_col_test;
  reg [4:0] nxt_phy_addr;
  reg nxt_an_restart;
  reg load_defaults;
  wire wr_ctrl;
  wire s_an;
  wire s_ffd;
  wire s_fhd;
  wire s_sfd;
  wire [4:0] s_addr;
  wire [15:0] ctrl_word;

  assign s_an = strap_sync[0];
  assign s_ffd = strap_sync[1];
  assign s_fhd = strap_sync[2];
  assign s_sfd = strap_sync[3];
  assign s_addr = strap_sync[8:4];
  // writes land only in the run state, isolate and powerdown do not block them
  assign wr_ctrl = mgmt_wr_en & ctrl_hit(mgmt_reg_addr) & (state_ff == ST_RUN);

  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_loopback = loopback_ff;
    nxt_speed = speed_ff;
    nxt_an_en = an_en_ff;
    nxt_pwrdn = pwrdn_ff;
    nxt_isolate = isolate_ff;
    nxt_restart = restart_ff;
    nxt_duplex = duplex_ff;
    nxt_col_test = col_test_ff;
    nxt_phy_addr = phy_addr_ff;
    nxt_an_restart = 1'b0;
    load_defaults = 1'b0;
    case (state_ff)
      ST_STRAP: begin
        // wait for the synchronisers to carry real pin levels
        if (cnt_ff == STRAP_LAST) begin
          load_defaults = 1'b1;
          nxt_state = ST_RUN;
          nxt_cnt = 10'h000;
        end else begin
          nxt_cnt = cnt_ff + 10'd1;
        end
      end
      ST_RUN: begin
        if (wr_ctrl && mgmt_wr_data[`PBC_BIT_SW_RESET]) begin
          nxt_state = ST_SWRST;
          nxt_cnt = 10'h000;
          nxt_loopback = 1'b0;
          nxt_pwrdn = 1'b0;
          nxt_restart = 1'b0;
          nxt_col_test = 1'b0;
        end else if (wr_ctrl) begin
          // bits 6..0 have no storage, so written values vanish
          nxt_loopback = mgmt_wr_data[`PBC_BIT_LOOPBACK];
          nxt_speed = mgmt_wr_data[`PBC_BIT_SPEED];
          nxt_an_en = mgmt_wr_data[`PBC_BIT_AN_EN];
          nxt_pwrdn = mgmt_wr_data[`PBC_BIT_PWRDN];
          nxt_isolate = mgmt_wr_data[`PBC_BIT_ISOLATE];
          nxt_duplex = mgmt_wr_data[`PBC_BIT_DUPLEX];
          nxt_col_test = mgmt_wr_data[`PBC_BIT_COL_TEST];
          if (mgmt_wr_data[`PBC_BIT_AN_RESTART] && mgmt_wr_data[`PBC_BIT_AN_EN]) begin
            nxt_restart = 1'b1;
            nxt_an_restart = 1'b1;
          end else if (!mgmt_wr_data[`PBC_BIT_AN_EN]) begin
            nxt_restart = 1'b0;
          end else if (an_done) begin
            nxt_restart = 1'b0;
          end
        end else if (an_done) begin
          nxt_restart = 1'b0;
        end
      end
      ST_SWRST: begin
        // the bit reads back as one for the full count
        if (cnt_ff == SWRST_LAST) begin
          load_defaults = 1'b1;
          nxt_state = ST_RUN;
          nxt_cnt = 10'h000;
        end else begin
          nxt_cnt = cnt_ff + 10'd1;
        end
      end
      default: begin
        nxt_state = ST_STRAP;
        nxt_cnt = 10'h000;
      end
    endcase
    if (load_defaults) begin
      nxt_phy_addr = s_addr;
      nxt_an_en = s_an;
      nxt_speed = s_an | s_ffd | s_fhd;
      nxt_duplex = ~s_an & (s_ffd | s_sfd);
      nxt_isolate = (s_addr == 5'h00);
      nxt_loopback = 1'b0;
      nxt_pwrdn = 1'b0;
      nxt_restart = 1'b0;
      nxt_col_test = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_STRAP;
      cnt_ff <= 10'h000;
      loopback_ff <= 1'b0;
      speed_ff <= 1'b0;
      an_en_ff <= 1'b0;
      pwrdn_ff <= 1'b0;
      isolate_ff <= 1'b0;
      restart_ff <= 1'b0;
      duplex_ff <= 1'b0;
      col_test_ff <= 1'b0;
      phy_addr_ff <= 5'h00;
      an_restart_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      loopback_ff <= nxt_loopback;
      speed_ff <= nxt_speed;
      an_en_ff <= nxt_an_en;
      pwrdn_ff <= nxt_pwrdn;
      isolate_ff <= nxt_isolate;
      restart_ff <= nxt_restart;
      duplex_ff <= nxt_duplex;
      col_test_ff <= nxt_col_test;
      phy_addr_ff <= nxt_phy_addr;
      an_restart_ff <= nxt_an_restart;
    end
  end

  // ****************************************
  // read path and link configuration
  // ****************************************
  assign ctrl_word = {(state_ff == ST_SWRST), loopback_ff, speed_ff, an_en_ff, pwrdn_ff,
                      isolate_ff, restart_ff, duplex_ff, col_test_ff, 7'h00};

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_rd_data_ff <= `PBC_CTRL_RESET;
      mgmt_rd_valid_ff <= 1'b0;
      an_enable_ff <= 1'b0;
      link_speed_100_ff <= 1'b0;
      link_full_duplex_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
    end else begin
      mgmt_rd_valid_ff <= mgmt_rd_en;
      if (mgmt_rd_en) begin
        mgmt_rd_data_ff <= ctrl_hit(mgmt_reg_addr) ? ctrl_word : 16'h0000;
      end
      an_enable_ff <= an_en_ff;
      // manual bits only count while autonegotiation is off
      link_speed_100_ff <= an_en_ff ? an_speed_100 : speed_ff;
      link_full_duplex_ff <= an_en_ff ? an_full_duplex : duplex_ff;
      soft_reset_ff <= (nxt_state == ST_SWRST);
    end
  end

  // ****************************************
  // mii side effects
  // ****************************************
  // loopback speed follows link_speed_100_ff; software keeps autoneg off meanwhile
  pbc_mii_path u_mii_path (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .loopback(loopback_ff),
    .isolate(isolate_ff),
    .powerdown(pwrdn_ff),
    .col_test(col_test_ff),
    .mac_txd(mac_txd),
    .mac_tx_en(mac_tx_en),
    .mac_tx_er(mac_tx_er),
    .pcs_rxd(pcs_rxd),
    .pcs_rx_dv(pcs_rx_dv),
    .pcs_rx_er(pcs_rx_er),
    .pcs_col(pcs_col),
    .pcs_crs(pcs_crs),
    .pcs_tx_clk(pcs_tx_clk),
    .pcs_rx_clk(pcs_rx_clk),
    .pcs_txd(pcs_txd),
    .pcs_tx_en(pcs_tx_en),
    .pcs_tx_er(pcs_tx_er),
    .twisted_pair_tx_oe(twisted_pair_tx_oe),
    .led_oe(led_oe),
    .mii_rxd(mii_rxd),
    .mii_rx_dv(mii_rx_dv),
    .mii_rx_er(mii_rx_er),
    .mii_col(mii_col),
    .mii_crs(mii_crs),
    .mii_tx_clk(mii_tx_clk),
    .mii_rx_clk(mii_rx_clk),
    .mii_out_oe(mii_out_oe)
  );

endmodule

`default_nettype wire

// File: tb/pbc_mac_model.sv
// mac transmit model sending a counting nibble stream
`timescale 1ns/1ps
`default_nettype none
module pbc_mac_model (
  input wire logic ref_clk,
  input wire logic send,
  output logic [3:0] mac_txd,
  output logic mac_tx_en,
  output logic mac_tx_er
);
  initial begin
    mac_txd = 4'h0;
    mac_tx_en = 1'b0;
    mac_tx_er = 1'b0;
  end
  // idle data is inverted each cycle so a stale nibble never passes for a sent one
  always @(posedge ref_clk) begin
    mac_tx_en <= #1 send;
    mac_txd <= #1 send ? mac_txd + 4'h1 : ~mac_txd;
  end
endmodule
`default_nettype wire

// File: tb/pbc_ctrl_assertions.sv
// port checks for the control register
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl_checker (
  input wire ref_clk,
  input wire reset_n,
  input wire [4:0] mgmt_reg_addr,
  input wire mgmt_wr_en,
  input wire [15:0] mgmt_wr_data,
  input wire mgmt_rd_en,
  input wire [15:0] mgmt_rd_data_ff,
  input wire mgmt_rd_valid_ff,
  input wire an_restart_ff,
  input wire an_enable_ff,
  input wire an_speed_100,
  input wire an_full_duplex,
  input wire link_speed_100_ff,
  input wire link_full_duplex_ff,
  input wire soft_reset_ff,
  input wire twisted_pair_tx_oe,
  input wire led_oe,
  input wire mii_out_oe
);
  reg [2:0] age_ff;
  reg [9:0] sr_cnt_ff;
  // writes in the strap settle window are skipped, so only count from edge five
  wire wr_base = mgmt_wr_en && mgmt_reg_addr == 5'h00 && age_ff >= 3'h4 && !soft_reset_ff;
  wire wr_ok = wr_base && !mgmt_wr_data[15];
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      age_ff <= 3'h0;
      sr_cnt_ff <= 10'h000;
    end else begin
      age_ff <= (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
      sr_cnt_ff <= soft_reset_ff ? sr_cnt_ff + 10'h001 : 10'h000;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_wr;
    wr_ok;
  endsequence
  sequence s_pulse;
    an_restart_ff ##1 !an_restart_ff;
  endsequence
  read_answer_a: assert property (mgmt_rd_en |=> mgmt_rd_valid_ff && mgmt_rd_data_ff[6:0] == 7'h00)
    else $error("read answer late or reserved bits set");
  soft_start_a: assert property (wr_base && mgmt_wr_data[15] |=> soft_reset_ff [*2])
    else $error("soft reset did not start");
  soft_length_a: assert property ($fell(soft_reset_ff) |-> sr_cnt_ff == 10'h1f4)
    else $error("soft reset too short");
  soft_cap_a: assert property (soft_reset_ff |-> sr_cnt_ff <= 10'h1f3)
    else $error("soft reset too long");
  reset_reads_one_a: assert property (mgmt_rd_valid_ff && $past(soft_reset_ff)
    && $past(mgmt_reg_addr) == 5'h00 |-> mgmt_rd_data_ff[15])
    else $error("reset bit read zero during soft reset");
  loopback_line_a: assert property (s_wr ##0 mgmt_wr_data[14] |=> !twisted_pair_tx_oe)
    else $error("line driver on in loopback");
  isolate_mii_a: assert property (s_wr ##0 mgmt_wr_data[10] |=> !mii_out_oe)
    else $error("mii driven while isolated");
  powerdown_float_a: assert property (s_wr ##0 mgmt_wr_data[11] |=> !led_oe && !twisted_pair_tx_oe && !mii_out_oe)
    else $error("outputs driven in powerdown");
  restart_pulse_a: assert property (s_wr ##0 (mgmt_wr_data[9] && mgmt_wr_data[12]) |=> s_pulse)
    else $error("restart pulse missing");
  link_auto_a: assert property (an_enable_ff && $past(an_enable_ff) |->
    link_speed_100_ff == $past(an_speed_100) && link_full_duplex_ff == $past(an_full_duplex))
    else $error("link not taken from negotiation");
endmodule
bind pbc_ctrl pbc_ctrl_checker u_pbc_ctrl_checker (.ref_clk(ref_clk), .reset_n(reset_n),
  .mgmt_reg_addr(mgmt_reg_addr), .mgmt_wr_en(mgmt_wr_en), .mgmt_wr_data(mgmt_wr_data),
  .mgmt_rd_en(mgmt_rd_en), .mgmt_rd_data_ff(mgmt_rd_data_ff), .mgmt_rd_valid_ff(mgmt_rd_valid_ff),
  .an_restart_ff(an_restart_ff), .an_enable_ff(an_enable_ff), .an_speed_100(an_speed_100),
  .an_full_duplex(an_full_duplex), .link_speed_100_ff(link_speed_100_ff),
  .link_full_duplex_ff(link_full_duplex_ff), .soft_reset_ff(soft_reset_ff),
  .twisted_pair_tx_oe(twisted_pair_tx_oe), .led_oe(led_oe), .mii_out_oe(mii_out_oe));
`default_nettype wire

// File: tb/pbc_ctrl_tb.sv
// testbench for the phy basic control register
`timescale 1ns/1ps
`default_nettype none
module pbc_ctrl_tb;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] straps = 4'h4;
  logic [4:0] paddr = 5'h03;
  logic [4:0] ra = 5'h00;
  logic [15:0] wd = 16'h0000;
  logic we = 1'b0;
  logic re = 1'b0;
  logic an_done = 1'b0;
  logic an_s = 1'b0;
  logic an_f = 1'b0;
  logic send = 1'b0;
  logic [9:0] pcs = 10'h0a5;
  logic [24:0] tbl [0:3];
  wire [15:0] rdata;
  wire [4:0] phy_addr;
  wire [3:0] mac_txd, pcs_txd, mii_rxd;
  wire rvalid, restart, spd, dup, mac_en, mac_er, tp_oe, led_oe, col, mii_oe, ptx_en, rx_dv;
  wire [3:0] prev_txd = mac_txd - 4'h1;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer cyc = 0;
  integer i;
  always #25 ref_clk = ~ref_clk;
  pbc_mac_model u_pbc_mac_model (.ref_clk(ref_clk), .send(send), .mac_txd(mac_txd),
    .mac_tx_en(mac_en), .mac_tx_er(mac_er));
  pbc_ctrl u_pbc_ctrl (.ref_clk(ref_clk), .reset_n(reset_n), .autoneg_strap(straps[3]),
    .fast_full_duplex_strap(straps[2]), .fast_half_duplex_strap(straps[1]),
    .slow_full_duplex_strap(straps[0]), .phy_addr_strap(paddr), .mgmt_reg_addr(ra),
    .mgmt_wr_en(we), .mgmt_wr_data(wd), .mgmt_rd_en(re), .mgmt_rd_data_ff(rdata),
    .mgmt_rd_valid_ff(rvalid), .phy_addr_ff(phy_addr), .an_done(an_done), .an_speed_100(an_s),
    .an_full_duplex(an_f), .an_restart_ff(restart), .an_enable_ff(), .link_speed_100_ff(spd),
    .link_full_duplex_ff(dup), .soft_reset_ff(), .mac_txd(mac_txd), .mac_tx_en(mac_en),
    .mac_tx_er(mac_er), .pcs_rxd(pcs[3:0]), .pcs_rx_dv(pcs[4]), .pcs_rx_er(pcs[5]),
    .pcs_col(pcs[6]), .pcs_crs(pcs[7]), .pcs_tx_clk(pcs[8]), .pcs_rx_clk(pcs[9]),
    .pcs_txd(pcs_txd), .pcs_tx_en(ptx_en), .pcs_tx_er(), .twisted_pair_tx_oe(tp_oe),
    .led_oe(led_oe), .mii_rxd(mii_rxd), .mii_rx_dv(rx_dv), .mii_rx_er(), .mii_col(col),
    .mii_crs(), .mii_tx_clk(), .mii_rx_clk(), .mii_out_oe(mii_oe));
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
        $display("STATUS OK");
      end else begin
        $display("STATUS NOT OK");
      end
      $finish;
    end
  endtask
  // stops a hung handshake; the full run needs about 2100 cycles
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      n_mismatch = n_mismatch + 1;
      finish_test;
    end
  end
  task chk(input [8*10-1:0] name, input [15:0] exp, input [15:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input [4:0] a, input [15:0] d);
    begin
      @(posedge ref_clk) #1;
      ra = a;
      wd = d;
      we = 1'b1;
      @(posedge ref_clk) #1;
      we = 1'b0;
    end
  endtask
  task rd(input [4:0] a, input [15:0] exp, input [15:0] mask);
    begin
      @(posedge ref_clk) #1;
      ra = a;
      re = 1'b1;
      @(posedge ref_clk) #1;
      re = 1'b0;
      chk("valid", 16'h0001, {15'h0000, rvalid});
      chk("ctrl", exp & mask, rdata & mask);
    end
  endtask
  task hw_reset;
    begin
      reset_n = 1'b0;
      tick(5);
      #1 reset_n = 1'b1;
      tick(4);
    end
  endtask
  initial begin
    tbl[0] = {4'h8, 5'h03, 16'h3000};
    tbl[1] = {4'h2, 5'h03, 16'h2000};
    tbl[2] = {4'h1, 5'h03, 16'h0100};
    tbl[3] = {4'h0, 5'h00, 16'h0400};
    hw_reset;
    rd(5'h00, 16'h2100, 16'hffff);
    wr(5'h00, 16'h21ff);
    rd(5'h00, 16'h2180, 16'hffff);
    wr(5'h01, 16'hffff);
    rd(5'h01, 16'h0000, 16'hffff);
    chk("speed", 16'h0001, {15'h0000, spd});
    chk("duplex", 16'h0001, {15'h0000, dup});
    send = 1'b1;
    tick(3);
    chk("col", 16'h0001, {15'h0000, col});
    $display("test registers and collision done");
    wr(5'h00, 16'h0000);
    tick(2);
    chk("speed", 16'h0000, {15'h0000, spd});
    chk("duplex", 16'h0000, {15'h0000, dup});
    an_s = 1'b1;
    wr(5'h00, 16'h1200);
    chk("restart", 16'h0001, {15'h0000, restart});
    tick(2);
    chk("an_link", 16'h0002, {14'h0000, spd, dup});
    rd(5'h00, 16'h1200, 16'hffff);
    @(posedge ref_clk) #1 an_done = 1'b1;
    @(posedge ref_clk) #1 an_done = 1'b0;
    rd(5'h00, 16'h1000, 16'hffff);
    $display("test autonegotiation done");
    wr(5'h00, 16'h6100);
    chk("line_oe", 16'h0000, {15'h0000, tp_oe});
    tick(3);
    chk("loop_spd", 16'h0001, {15'h0000, spd});
    chk("pcs_txd", 16'h0000, {12'h000, pcs_txd});
    @(negedge ref_clk);
    chk("loop_rxd", {12'h000, prev_txd}, {12'h000, mii_rxd});
    chk("loop_dv", 16'h0001, {15'h0000, rx_dv});
    chk("loop_txen", 16'h0000, {15'h0000, ptx_en});
    wr(5'h00, 16'h2500);
    chk("mii_oe", 16'h0000, {15'h0000, mii_oe});
    rd(5'h00, 16'h2500, 16'hffff);
    chk("pcs_txd", 16'h0000, {12'h000, pcs_txd});
    chk("pcs_tx_en", 16'h0000, {15'h0000, ptx_en});
    wr(5'h00, 16'h2900);
    chk("pd_oe", 16'h0000, {13'h0000, led_oe, tp_oe, mii_oe});
    hw_reset;
    rd(5'h00, 16'h2100, 16'hffff);
    $display("test loopback isolate powerdown done");
    for (i = 0; i < 4; i = i + 1) begin
      straps = tbl[i][24:21];
      paddr = tbl[i][20:16];
      wr(5'h00, 16'h8000);
      rd(5'h00, 16'h8000, 16'h8000);
      wr(5'h00, 16'h4000);
      tick(500);
      rd(5'h00, tbl[i][15:0], 16'hffff);
      chk("phy_addr", {11'h000, paddr}, {11'h000, phy_addr});
    end
    $display("test soft reset straps done");
    finish_test;
  end
endmodule
`default_nettype wire
